// ===== iop_pkg.sv
`default_nettype none
package iop_pkg;
    // ****************************************
    // Global lines
    // ****************************************
    localparam int unsigned LINES          = 8;
    localparam int unsigned LINE_IDX_W     = 3;
    localparam logic [3:0]  TILE_MAX_LINES = 4'h4;
    localparam logic [2:0]  DIFF_LINE      = 3'h7;
    localparam logic [7:0]  LINES_RST      = 8'h00;
    // ****************************************
    // I/O pair
    // ****************************************
    localparam int unsigned CELLS          = 2;
    localparam logic [1:0]  PAIR_RST       = 2'h0;
    // ****************************************
    // Capture buffer
    // ****************************************
    localparam int unsigned FIFO_W         = 4;
    localparam int unsigned FIFO_D         = 32;
    localparam int unsigned FIFO_AW        = 5;
    localparam int unsigned FIFO_CW        = 6;

    typedef enum logic [1:0] {
        IOP_CFG = 2'b00,
        IOP_RUN = 2'b01,
        IOP_HIZ = 2'b10
    } iop_state_e;
endpackage
`default_nettype wire

// ===== iop_mem.sv
`timescale 1ns/10ps
`default_nettype none
module iop_mem #(
    parameter int unsigned W  = iop_pkg::FIFO_W,
    parameter int unsigned D  = iop_pkg::FIFO_D,
    parameter int unsigned AW = iop_pkg::FIFO_AW
) (
    // Clock
    input  wire logic          clk,
    input  wire logic          ce,
    // Write port
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [W-1:0]  wdata,
    // Read port
    input  wire logic [AW-1:0] raddr,
    output logic      [W-1:0]  rdata
);
    logic [W-1:0] mem_reg [D];

    always_ff @(posedge clk) begin
        if (ce && we) begin
            mem_reg[waddr] <= wdata;
        end
    end

    // Read data is registered; a write to the same word shows a cycle later
    always_ff @(posedge clk) begin
        if (ce) begin
            rdata <= mem_reg[raddr];
        end
    end
endmodule // iop_mem
`default_nettype wire

// ===== iop_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module iop_fifo #(
    parameter int unsigned W  = iop_pkg::FIFO_W,
    parameter int unsigned D  = iop_pkg::FIFO_D,
    parameter int unsigned AW = iop_pkg::FIFO_AW,
    parameter int unsigned CW = iop_pkg::FIFO_CW
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic         ce,
    // Fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW-1:0] rd_next;
    logic [CW-1:0] cnt_reg;
    logic          fresh_reg;
    logic          wr_fire;
    logic          rd_fire;

    assign in_ready  = (cnt_reg != CW'(D));
    assign out_valid = (cnt_reg != '0) && !fresh_reg;
    assign wr_fire   = in_valid && in_ready;
    assign rd_fire   = out_valid && out_ready;
    assign rd_next   = rd_fire ? AW'(rd_reg + 1'b1) : rd_reg;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_reg    <= '0;
            rd_reg    <= '0;
            cnt_reg   <= '0;
            fresh_reg <= 1'b0;
        end else if (ce) begin
            if (wr_fire) begin
                wr_reg <= AW'(wr_reg + 1'b1);
            end
            rd_reg <= rd_next;
            cnt_reg <= CW'(cnt_reg + CW'(wr_fire) - CW'(rd_fire));
            // Word written where the read port looks is not yet in rdata
            fresh_reg <= wr_fire && (wr_reg == rd_next);
        end
    end

    iop_mem #(.W(W), .D(D), .AW(AW)) u_mem (
        .clk   (clk),
        .ce    (ce),
        .we    (wr_fire),
        .waddr (wr_reg),
        .wdata (in_data),
        .raddr (rd_next),
        .rdata (out_data)
    );
endmodule // iop_fifo
`default_nettype wire

// ===== iop_pair.sv
// Contract
// - Pair shares capture clock, launch clock, enable
// - Capture clock drives only input flops
// - Launch clock drives output and enable flops
// - Pair enable gates all flops, else always; in_direct behind the hold latch is not gated by it
// - Output double rate: rise and fall registers
// - Input double rate: two separate samples
// - Eight lines from dedicated pin or fabric
// - Unused global lines switched off
// - At most four lines to tile logic
// - Even lines reset, odd lines enable tile
// - Even lines only for pair enable
// - Dedicated pin bypasses hold latch
// - Two dedicated pins per bank, eight
// - Line seven takes differential clock directly
// - Float all pads during configuration
// - Test controller can float pads
// - Global reset holds flops during configuration
// - I/O flops reset; optional output inversion
// - Enable high drives pad, low floats
`timescale 1ns/10ps
`default_nettype none
module iop_pair (
    // Clock, reset, freeze
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        ce,
    // Configuration and test float
    input  wire logic        cfg_busy,
    input  wire logic        jtag_hiz,
    // Global line sources
    input  wire logic [7:0]  global_pin_input,
    input  wire logic [7:0]  fabric_line_src,
    input  wire logic [7:0]  line_from_pin,
    input  wire logic [7:0]  line_used,
    input  wire logic        diff_clk_en,
    input  wire logic        diff_comp_pad,
    output logic      [7:0]  global_line_driver,
    // Pair clock selection
    input  wire logic [2:0]  in_clk_sel,
    input  wire logic [2:0]  out_clk_sel,
    input  wire logic        pair_ce_used,
    input  wire logic [1:0]  pair_ce_sel,
    // Logic tile routing
    input  wire logic [7:0]  tile_logic_mask,
    input  wire logic [1:0]  tile_rst_sel,
    input  wire logic [1:0]  tile_ce_sel,
    output logic      [7:0]  tile_logic,
    output logic             tile_rst,
    output logic             tile_ce,
    output logic             tile_route_err,
    // Pads
    input  wire logic [1:0]  pad_in,
    output logic      [1:0]  pad_out,
    output logic      [1:0]  pad_oe,
    // Fabric output side
    input  wire logic [1:0]  d_out_0,
    input  wire logic [1:0]  d_out_1,
    input  wire logic [1:0]  oe_in,
    input  wire logic [1:0]  ddr_out_en,
    input  wire logic [1:0]  out_invert,
    // Fabric input side
    input  wire logic        hold_en,
    output logic      [1:0]  in_direct,
    output logic      [1:0]  d_in_0,
    output logic      [1:0]  d_in_1,
    // Capture stream
    output logic             s_valid,
    input  wire logic        s_ready,
    output logic      [3:0]  s_data
);
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic line_at(input logic [7:0] v, input logic [2:0] i);
        return v[i];
    endfunction

    function automatic logic [3:0] ones(input logic [7:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int k = 0; k < iop_pkg::LINES; k++) begin
            n = 4'(n + {3'h0, v[k]});
        end
        return n;
    endfunction

    iop_pkg::iop_state_e state_reg;
    iop_pkg::iop_state_e state_next;
    logic [7:0] line_next;
    logic       oclk;
    logic       iclk;
    logic       oclk_prev_reg;
    logic       iclk_prev_reg;
    logic       out_rise;
    logic       out_fall;
    logic       in_rise;
    logic       in_fall;
    logic       pair_en;
    logic       run;
    logic [1:0] q0_reg;
    logic [1:0] q1_reg;
    logic [1:0] oe_reg;
    logic       push_reg;
    logic       fifo_in_ready;

    // ****************************************
    // Configuration state
    // ****************************************
    always_comb begin
        if (cfg_busy) begin
            state_next = iop_pkg::IOP_CFG;
        end else if (jtag_hiz) begin
            state_next = iop_pkg::IOP_HIZ;
        end else begin
            state_next = iop_pkg::IOP_RUN;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= iop_pkg::IOP_CFG;
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    always_comb begin
        case (state_reg)
            iop_pkg::IOP_RUN: run = 1'b1;
            iop_pkg::IOP_CFG: run = 1'b0;
            iop_pkg::IOP_HIZ: run = 1'b1;
            default:          run = 1'b0;
        endcase
    end

    // ****************************************
    // Global lines
    // ****************************************
    // Dedicated pins feed straight in, never through the hold latch
    always_comb begin
        for (int i = 0; i < iop_pkg::LINES; i++) begin
            line_next[i] = line_from_pin[i] ? global_pin_input[i] : fabric_line_src[i];
        end
        if (diff_clk_en && line_from_pin[iop_pkg::DIFF_LINE]) begin
            line_next[iop_pkg::DIFF_LINE] = global_pin_input[iop_pkg::DIFF_LINE] & ~diff_comp_pad;
        end
        line_next = line_next & line_used;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            global_line_driver <= iop_pkg::LINES_RST;
        end else if (ce) begin
            global_line_driver <= line_next;
        end
    end

    // ****************************************
    // Logic tile routing
    // ****************************************
    // An over-subscribed mask is refused whole rather than truncated
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tile_logic     <= iop_pkg::LINES_RST;
            tile_rst       <= 1'b0;
            tile_ce        <= 1'b0;
            tile_route_err <= 1'b0;
        end else if (ce) begin
            tile_route_err <= ones(tile_logic_mask) > iop_pkg::TILE_MAX_LINES;
            tile_logic     <= (ones(tile_logic_mask) > iop_pkg::TILE_MAX_LINES) ?
                              iop_pkg::LINES_RST : (global_line_driver & tile_logic_mask);
            tile_rst       <= line_at(global_line_driver, {tile_rst_sel, 1'b0});
            tile_ce        <= line_at(global_line_driver, {tile_ce_sel, 1'b1});
        end
    end

    // ****************************************
    // Pair clocks and enable
    // ****************************************
    // Pair clocks are global lines sampled on clk; edges are found by compare
    assign iclk     = line_at(global_line_driver, in_clk_sel);
    assign oclk     = line_at(global_line_driver, out_clk_sel);
    assign pair_en  = !pair_ce_used || line_at(global_line_driver, {pair_ce_sel, 1'b0});
    assign out_rise = oclk && !oclk_prev_reg;
    assign out_fall = !oclk && oclk_prev_reg;
    assign in_rise  = iclk && !iclk_prev_reg;
    assign in_fall  = !iclk && iclk_prev_reg;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            oclk_prev_reg <= 1'b0;
            iclk_prev_reg <= 1'b0;
        end else if (ce) begin
            oclk_prev_reg <= oclk;
            iclk_prev_reg <= iclk;
        end
    end

    // ****************************************
    // Output and enable flops
    // ****************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q0_reg <= iop_pkg::PAIR_RST;
            q1_reg <= iop_pkg::PAIR_RST;
            oe_reg <= iop_pkg::PAIR_RST;
        end else if (ce) begin
            if (state_reg == iop_pkg::IOP_CFG) begin
                q0_reg <= iop_pkg::PAIR_RST;
                q1_reg <= iop_pkg::PAIR_RST;
                oe_reg <= iop_pkg::PAIR_RST;
            end else if (pair_en) begin
                if (out_rise) begin
                    q0_reg <= d_out_0;
                    oe_reg <= oe_in;
                end
                if (out_fall) begin
                    q1_reg <= d_out_1;
                end
            end
        end
    end

    // Pad float is forced from the state, so it overrides the enable flop
    always_comb begin
        for (int c = 0; c < iop_pkg::CELLS; c++) begin
            pad_out[c] = ((ddr_out_en[c] && !oclk) ? q1_reg[c] : q0_reg[c]) ^ out_invert[c];
            pad_oe[c]  = oe_reg[c] && (state_reg == iop_pkg::IOP_RUN);
        end
    end

    // ****************************************
    // Input flops and hold latch
    // ****************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            in_direct <= iop_pkg::PAIR_RST;
        end else if (ce && !hold_en) begin
            in_direct <= pad_in;
        end
    end

    // A full buffer stalls capture; pairs arriving while full are dropped, none overwritten
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            d_in_0   <= iop_pkg::PAIR_RST;
            d_in_1   <= iop_pkg::PAIR_RST;
            push_reg <= 1'b0;
        end else if (ce) begin
            push_reg <= 1'b0;
            if (state_reg == iop_pkg::IOP_CFG) begin
                d_in_0 <= iop_pkg::PAIR_RST;
                d_in_1 <= iop_pkg::PAIR_RST;
            end else if (pair_en && fifo_in_ready) begin
                if (in_rise) begin
                    d_in_0 <= pad_in;
                end
                if (in_fall) begin
                    d_in_1   <= pad_in;
                    push_reg <= 1'b1;
                end
            end
        end
    end

    iop_fifo u_fifo (
        .clk       (clk),
        .rstn      (rstn),
        .ce        (ce),
        .in_valid  (push_reg),
        .in_ready  (fifo_in_ready),
        .in_data   ({d_in_1, d_in_0}),
        .out_valid (s_valid),
        .out_ready (s_ready),
        .out_data  (s_data)
    );

    // ****************************************
    // Checks
    // ****************************************
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    chk_float_cfg: assert property (
        (state_reg == iop_pkg::IOP_CFG) |-> (pad_oe == 2'h0)
    ) else $error("pad driven during configuration");

    chk_test_float: assert property (
        (ce && jtag_hiz) |=> (pad_oe == 2'h0)
    ) else $error("pad driven under test float");

    chk_cfg_reset: assert property (
        (ce && state_reg == iop_pkg::IOP_CFG) |=> (q0_reg == 2'h0 && oe_reg == 2'h0 && d_in_1 == 2'h0)
    ) else $error("pair flops not reset in configuration");

    chk_launch_rise: assert property (
        (ce && run && pair_en && out_rise) |=> (q0_reg == $past(d_out_0) && oe_reg == $past(oe_in))
    ) else $error("launch rise not taken");

    chk_capture_fall: assert property (
        (ce && run && pair_en && fifo_in_ready && in_fall) |=> (d_in_1 == $past(pad_in)) ##2 (s_valid || !ce)
    ) else $error("capture fall not taken");

    chk_pair_hold: assert property (
        (ce && run && !pair_en) |=> ($stable(q0_reg) && $stable(q1_reg) && $stable(d_in_0))
    ) else $error("pair flop moved while disabled");

    chk_lines_off: assert property (
        ce |=> ((global_line_driver & ~$past(line_used)) == 8'h00)
    ) else $error("unused global line toggling");

    chk_tile_limit: assert property (
        ce |=> (ones(tile_logic) <= iop_pkg::TILE_MAX_LINES)
    ) else $error("too many lines into tile");

    chk_ddr_mux: assert property (
        (ddr_out_en[0] && !out_invert[0] && oclk) |-> (pad_out[0] == q0_reg[0])
    ) else $error("double rate mux wrong phase");

    chk_capture_rise: assert property (
        (ce && run && pair_en && fifo_in_ready && in_rise) |=> (d_in_0 == $past(pad_in))
    ) else $error("capture rise not taken");

    chk_launch_fall: assert property (
        (ce && run && pair_en && out_fall) |=> (q1_reg == $past(d_out_1))
    ) else $error("launch fall not taken");

    // Output side must ignore capture clock edges entirely
    chk_out_launch_only: assert property (
        (ce && run && !out_rise && !out_fall) |=> ($stable(q0_reg) && $stable(q1_reg) && $stable(oe_reg))
    ) else $error("output flop moved without launch edge");

    chk_pair_ce_even: assert property (
        (ce && run && pair_ce_used && !global_line_driver[{pair_ce_sel, 1'b0}]) |=>
            ($stable(q0_reg) && $stable(oe_reg) && $stable(d_in_1))
    ) else $error("pair enabled by a line other than its even line");

    chk_ce_freeze: assert property (
        !ce |=> ($stable(global_line_driver) && $stable(q0_reg) && $stable(oe_reg) && $stable(d_in_1))
    ) else $error("state moved while clock enable low");

    cov_ddr_out: cover property (ce && run && out_rise ##[1:8] out_fall);
    cov_capture: cover property (push_reg && fifo_in_ready);
    cov_full:    cover property (run && !fifo_in_ready);
    cov_float:   cover property (state_reg == iop_pkg::IOP_HIZ);
endmodule // iop_pair
`default_nettype wire

// ===== iop_board.sv
`timescale 1ns/10ps
`default_nettype none
module iop_board (
    // Device side
    input  wire logic [1:0] pad_out,
    input  wire logic [1:0] pad_oe,
    output logic      [1:0] pad_in,
    output logic      [7:0] global_pin_input,
    output logic            diff_comp_pad,
    // Bench controls
    input  wire logic [1:0] board_level,
    input  wire logic [7:0] gpin_level,
    input  wire logic       comp_level
);
    // ****************************************
    // Pad resolution
    // ****************************************
    // Board lets go of a pad while the cell drives it, so no contention is modelled
    assign pad_in           = (pad_oe & pad_out) | (~pad_oe & board_level);
    assign global_pin_input = gpin_level;
    assign diff_comp_pad    = comp_level;
endmodule // iop_board
`default_nettype wire

// ===== tb_io_pair_ddr_register_cell.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp, msg) begin n_tests++; if ((got) !== (exp)) begin \
    mismatches++; $display("CHECK FAILED at %0t: %s", $time, msg); end end
module tb_io_pair_ddr_register_cell;
    // ****************************************
    // Signals
    // ****************************************
    localparam logic [7:0] TILE_PAT = 8'h36;
    logic       clk             = 1'b0;
    logic       rstn            = 1'b0;
    logic       ce              = 1'b1;
    logic       cfg_busy        = 1'b1;
    logic       jtag_hiz        = 1'b0;
    logic [7:0] gpin_level      = 8'h00;
    logic [7:0] fabric_line_src = 8'h00;
    logic [7:0] line_from_pin   = 8'h00;
    logic [7:0] line_used       = 8'hFF;
    logic       diff_clk_en     = 1'b0;
    logic       comp_level      = 1'b0;
    logic [2:0] in_clk_sel      = 3'h0;
    logic [2:0] out_clk_sel     = 3'h1;
    logic       pair_ce_used    = 1'b0;
    logic [1:0] pair_ce_sel     = 2'h1;
    logic [7:0] tile_logic_mask = 8'h00;
    logic [1:0] tile_rst_sel    = 2'h0;
    logic [1:0] tile_ce_sel     = 2'h0;
    logic [1:0] board_level     = 2'h0;
    logic [1:0] d_out_0         = 2'h0;
    logic [1:0] d_out_1         = 2'h0;
    logic [1:0] oe_in           = 2'h3;
    logic [1:0] ddr_out_en      = 2'h0;
    logic [1:0] out_invert      = 2'h0;
    logic       hold_en         = 1'b0;
    logic       s_ready         = 1'b0;
    logic [7:0] global_pin_input;
    logic       diff_comp_pad;
    logic [7:0] global_line_driver;
    logic [7:0] tile_logic;
    logic       tile_rst;
    logic       tile_ce;
    logic       tile_route_err;
    logic [1:0] pad_in;
    logic [1:0] pad_out;
    logic [1:0] pad_oe;
    logic [1:0] in_direct;
    logic [1:0] d_in_0;
    logic [1:0] d_in_1;
    logic       s_valid;
    logic [3:0] s_data;
    int         mismatches      = 0;
    int         n_tests         = 0;

    iop_pair DUT (
        .clk, .rstn, .ce, .cfg_busy, .jtag_hiz, .global_pin_input, .fabric_line_src, .line_from_pin,
        .line_used, .diff_clk_en, .diff_comp_pad, .global_line_driver, .in_clk_sel, .out_clk_sel,
        .pair_ce_used, .pair_ce_sel, .tile_logic_mask, .tile_rst_sel, .tile_ce_sel, .tile_logic,
        .tile_rst, .tile_ce, .tile_route_err, .pad_in, .pad_out, .pad_oe, .d_out_0, .d_out_1, .oe_in,
        .ddr_out_en, .out_invert, .hold_en, .in_direct, .d_in_0, .d_in_1, .s_valid, .s_ready, .s_data
    );
    iop_board board (
        .pad_out, .pad_oe, .pad_in, .global_pin_input, .diff_comp_pad, .board_level, .gpin_level, .comp_level
    );

    initial begin
        forever #12.5 clk = ~clk;
    end

    // ****************************************
    // Helpers
    // ****************************************
    task automatic step(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
        end
    endtask

    // Three edges cover the line register and the pair flop behind it
    task automatic set_line(input int idx, input logic val);
        fabric_line_src[idx] = val;
        step(3);
    endtask

    task automatic summarize();
        $display("Checks: %0d, mismatches: %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_ddr_out();
        ddr_out_en = 2'h3;
        d_out_0 = 2'h2;
        d_out_1 = 2'h1;
        set_line(1, 1'b1);
        `CHK(pad_oe, 2'h3, "oe loaded on launch rise")
        `CHK(pad_out, 2'h2, "rise register while high")
        d_out_0 = 2'h1;
        set_line(0, 1'b1);
        set_line(0, 1'b0);
        `CHK(pad_out, 2'h2, "capture clock moved output flop")
        set_line(1, 1'b0);
        `CHK(pad_out, 2'h1, "fall register while low")
        out_invert = 2'h2;
        step(1);
        `CHK(pad_out, 2'h3, "inversion after flop")
        ddr_out_en = 2'h0;
        out_invert = 2'h0;
        step(1);
        `CHK(pad_out, 2'h2, "single rate shows rise flop")
        oe_in = 2'h1;
        set_line(1, 1'b1);
        `CHK(pad_oe, 2'h1, "oe low floats one cell")
        `CHK(pad_out, 2'h1, "both cells on shared clock")
        set_line(1, 1'b0);
        $display("t_ddr_out done");
    endtask

    task automatic t_ce();
        pair_ce_used = 1'b1;
        d_out_0 = 2'h2;
        set_line(1, 1'b1);
        `CHK(pad_out, 2'h1, "enable low holds flops")
        set_line(1, 1'b0);
        set_line(2, 1'b1);
        set_line(1, 1'b1);
        `CHK(pad_out, 2'h2, "even line enables pair")
        pair_ce_used = 1'b0;
        set_line(2, 1'b0);
        set_line(1, 1'b0);
        ce = 1'b0;
        d_out_0 = 2'h3;
        set_line(1, 1'b1);
        `CHK(global_line_driver[1], 1'b0, "clock enable freezes lines")
        `CHK(pad_out, 2'h2, "clock enable freezes pair flops")
        ce = 1'b1;
        set_line(1, 1'b0);
        $display("t_ce done");
    endtask

    task automatic t_fifo();
        int k;
        int n;
        oe_in = 2'h0;
        set_line(1, 1'b1);
        set_line(1, 1'b0);
        s_ready = 1'b1;
        step(8);
        s_ready = 1'b0;
        `CHK(s_valid, 1'b0, "buffer flushed")
        // Two words past the depth: capture must stall, not overwrite
        for (k = 0; k < 34; k++) begin
            // Refused words carry inverted data so an overwrite would show
            board_level = k[1:0] ^ {2{k[5]}};
            set_line(0, 1'b1);
            board_level = k[3:2] ^ {2{k[5]}};
            set_line(0, 1'b0);
            if (k == 6) begin
                `CHK({d_in_1, d_in_0}, 4'h6, "rise and fall samples")
            end
        end
        for (k = 0; k < 32; k++) begin
            n = 0;
            while (s_valid !== 1'b1 && n < 20) begin
                step(1);
                n++;
            end
            `CHK(s_data, k[3:0], "stream word")
            s_ready = 1'b1;
            step(1);
            s_ready = 1'b0;
            step(1);
        end
        `CHK(s_valid, 1'b0, "refused words not stored")
        $display("t_fifo done");
    endtask

    task automatic t_lines();
        hold_en = 1'b1;
        board_level = 2'h0;
        line_from_pin = 8'hF0;
        gpin_level = 8'hA5;
        fabric_line_src = 8'h5A;
        step(3);
        `CHK(global_line_driver, 8'hAA, "pin and fabric sources")
        `CHK(in_direct, 2'h3, "hold latch frozen")
        line_used = 8'h0F;
        step(3);
        `CHK(global_line_driver, 8'h0A, "unused lines off")
        line_used = 8'hFF;
        diff_clk_en = 1'b1;
        gpin_level = 8'h80;
        step(3);
        `CHK(global_line_driver[7], 1'b1, "differential true")
        comp_level = 1'b1;
        step(3);
        `CHK(global_line_driver[7], 1'b0, "differential complement")
        hold_en = 1'b0;
        diff_clk_en = 1'b0;
        comp_level = 1'b0;
        gpin_level = 8'h00;
        line_from_pin = 8'h00;
        fabric_line_src = 8'h00;
        step(3);
        `CHK(in_direct, 2'h0, "hold latch follows pad")
        $display("t_lines done");
    endtask

    task automatic t_tile();
        int s;
        fabric_line_src = TILE_PAT;
        tile_logic_mask = 8'hF0;
        step(4);
        `CHK(tile_logic, 8'h30, "four lines pass")
        `CHK(tile_route_err, 1'b0, "four lines legal")
        tile_logic_mask = 8'hF8;
        step(4);
        `CHK(tile_logic, 8'h00, "five lines refused")
        `CHK(tile_route_err, 1'b1, "five lines flagged")
        for (s = 0; s < 4; s++) begin
            tile_rst_sel = s[1:0];
            tile_ce_sel = s[1:0];
            step(4);
            `CHK(tile_rst, TILE_PAT[2*s], "reset from even line")
            `CHK(tile_ce, TILE_PAT[2*s+1], "enable from odd line")
        end
        fabric_line_src = 8'h00;
        step(3);
        $display("t_tile done");
    endtask

    task automatic t_float();
        oe_in = 2'h3;
        set_line(1, 1'b1);
        set_line(1, 1'b0);
        `CHK(pad_oe, 2'h3, "pads driven")
        jtag_hiz = 1'b1;
        step(3);
        `CHK(pad_oe, 2'h0, "test float")
        jtag_hiz = 1'b0;
        step(3);
        `CHK(pad_oe, 2'h3, "test float released")
        cfg_busy = 1'b1;
        step(3);
        `CHK(pad_oe, 2'h0, "float while configuring")
        cfg_busy = 1'b0;
        step(3);
        `CHK(pad_oe, 2'h0, "oe flops cleared by configuration")
        fabric_line_src = 8'h04;
        step(3);
        rstn = 1'b0;
        step(1);
        `CHK(global_line_driver, iop_pkg::LINES_RST, "mid-run reset")
        rstn = 1'b1;
        fabric_line_src = 8'h00;
        step(3);
        $display("t_float done");
    endtask

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        step(1);
        `CHK(pad_oe, 2'h0, "float in reset")
        `CHK(global_line_driver, iop_pkg::LINES_RST, "lines in reset")
        step(1);
        rstn = 1'b1;
        d_out_0 = 2'h3;
        set_line(1, 1'b1);
        `CHK(pad_oe, 2'h0, "float while configuring")
        `CHK(pad_out, 2'h0, "pair flops held")
        set_line(1, 1'b0);
        cfg_busy = 1'b0;
        step(2);
        t_ddr_out();
        t_ce();
        t_fifo();
        t_lines();
        t_tile();
        t_float();
        summarize();
    end

    // Whole run is under 2000 cycles; this allows a wide margin
    initial begin
        #200000;
        mismatches++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        summarize();
    end
endmodule // tb_io_pair_ddr_register_cell
`default_nettype wire
